// ### ccpu_pin_model.sv
// partner model: outside world driving the two unit pins
`timescale 1ns/1ns
module ccpu_pin_model (
    input  wire logic       clk_sys,
    input  wire logic [1:0] ext_lvl,
    input  wire logic [1:0] as_output,
    input  wire logic [1:0] latch_out,
    output logic      [1:0] pin
);
    // a pin set as output shows the unit latch, so it can capture itself
    always_ff @(posedge clk_sys) begin
        pin <= (as_output & latch_out) | (~as_output & ext_lvl);
    end
endmodule

// ### ccpu_pkg.sv
// package: register map, mode codes and field positions of the capture/compare/pwm unit
package ccpu_pkg;
    localparam logic [7:0] OFF_FLAG2   = 8'h0d;
    localparam logic [7:0] OFF_VAL1_LO = 8'h15;
    localparam logic [7:0] OFF_VAL1_HI = 8'h16;
    localparam logic [7:0] OFF_CTRL1   = 8'h17;
    localparam logic [7:0] OFF_VAL2_LO = 8'h1b;
    localparam logic [7:0] OFF_VAL2_HI = 8'h1c;
    localparam logic [7:0] OFF_CTRL2   = 8'h1d;
    localparam logic [7:0] OFF_ENA2    = 8'h8d;
    localparam logic [7:0] OFF_FLAG1   = 8'h0c;
    localparam logic [7:0] OFF_ENA1    = 8'h8c;
    localparam int FLAG1_BIT   = 2;
    localparam int TAOVF_BIT   = 0;
    localparam int FLAG2_BIT   = 0;
    localparam int MODE_LSB    = 0;
    localparam int DUTY_LSB    = 4;
    localparam logic [3:0] MODE_OFF    = 4'h0;
    localparam logic [3:0] MODE_CAP_FE = 4'h4;
    localparam logic [3:0] MODE_CAP_RE = 4'h5;
    localparam logic [3:0] MODE_CAP_4  = 4'h6;
    localparam logic [3:0] MODE_CAP_16 = 4'h7;
    localparam logic [3:0] MODE_CMP_HI = 4'h8;
    localparam logic [3:0] MODE_CMP_LO = 4'h9;
    localparam logic [3:0] MODE_CMP_SW = 4'ha;
    localparam logic [3:0] MODE_CMP_EV = 4'hb;
    localparam logic [5:0] CTRL_MASK   = 6'h3f;
    localparam logic [3:0] PRESC_4     = 4'h3;
    localparam logic [3:0] PRESC_16    = 4'hf;
    typedef enum logic [1:0] {CCPU_OFF, CCPU_CAP, CCPU_CMP, CCPU_PWM} ccpu_mode_e;
endpackage

// ### ccpu_top.sv
// two capture/compare/pwm units with register port
//
// Behaviour
// - capture copies full 16-bit timer a count into value register on event.
// - capture event: falling, rising, every 4th or every 16th rising edge.
// - capture codes 0100, 0101, 0110, 0111.
// - each capture sets the unit event flag until software clears it.
// - new capture overwrites value register even if unread.
// - capture looks at the pin level, so port writes may capture.
// - prescaler counter cleared when unit off or not capturing.
// - direct prescale switch keeps counter; software writes zero first.
// - compare value with timer a; on equality act on pin and set flag.
// - compare codes 1000 high, 1001 low, 1010 flag, 1011 trigger.
// - writing zero to control forces the output latch low.
// - flag-only compare leaves pin unchanged.
// - trigger resets timer a; second unit also starts conversion if enabled.
// - trigger-caused timer a reset does not set overflow flag.
// - code 0000 turns unit off; 11xx selects pwm.
// - pwm drives pin with up to 10-bit duty when direction bit cleared.
// - after timer b equals period: clear timer b, set pin unless 0%, latch duty.
// - timer b postscaler does not affect pwm period.
// - duty is low byte as msbs and control bits 5:4 as lsbs.
// - duty writes take effect at period end; high byte read-only in pwm.
// - pin cleared when buffered duty equals timer b with 2-bit sub-count.
// - duty longer than period never clears pin.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
module ccpu_top
    import ccpu_pkg::*;
#(
    parameter int UNITS = 2
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic [15:0] timer_a_count,
    input  wire logic [7:0]  timer_b_count,
    input  wire logic [7:0]  timer_b_period,
    input  wire logic [1:0]  timer_b_subcount,
    input  wire logic        timer_b_inc,
    input  wire logic        adc_enabled,
    input  wire logic [1:0]  unit_pin_in,
    output logic      [1:0]  unit_pin_out,
    output logic             timer_a_clear,
    output logic             timer_b_clear,
    output logic             adc_start,
    output logic             first_unit_event_flag,
    input  wire logic        first_unit_flag_clear,
    output logic             first_unit_event_enable
);
    // the register map names exactly two units, so refuse any other count
    if (UNITS != 2) begin : g_units_chk
        $error("ccpu_top serves exactly two units");
    end

    logic [7:0]  val_lo_q [2];
    logic [7:0]  val_hi_q [2];
    logic [5:0]  ctrl_q   [2];
    logic [1:0]  duty_lsb_q [2];
    logic [3:0]  presc_q  [2];
    logic [1:0]  flag_q;
    logic [1:0]  ena_q;
    logic [1:0]  out_q;
    logic [1:0]  pin_s1_q, pin_s2_q, pin_s3_q;
    logic [1:0]  cap_ev, cmp_ev, trig_ev, period_end;
    logic [1:0]  wr_lo, wr_hi, wr_ctrl;
    logic [7:0]  rdata_q;

    // decode of the mode field into a coarse class
    function automatic ccpu_mode_e mode_class(input logic [3:0] m);
        if (m[3:2] == 2'b11)  return CCPU_PWM;
        else if (m[3])        return CCPU_CMP;
        else if (m[2])        return CCPU_CAP;
        else                  return CCPU_OFF;
    endfunction

    // pin synchroniser; third stage only feeds edge detection
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pin_s1_q <= 2'h0;
            pin_s2_q <= 2'h0;
            pin_s3_q <= 2'h0;
        end else begin
            pin_s1_q <= unit_pin_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    generate
        for (genvar u = 0; u < 2; u++) begin : g_unit
            logic [3:0]  mode;
            ccpu_mode_e  cls;
            logic        rise, fall, edge_ok;
            logic [9:0]  duty_buf;
            assign mode = ctrl_q[u][MODE_LSB +: 4];
            assign cls  = mode_class(mode);
            assign rise = pin_s2_q[u] & ~pin_s3_q[u];
            assign fall = ~pin_s2_q[u] & pin_s3_q[u];
            assign wr_lo[u]   = reg_wr && reg_addr == (u == 0 ? OFF_VAL1_LO : OFF_VAL2_LO);
            assign wr_hi[u]   = reg_wr && reg_addr == (u == 0 ? OFF_VAL1_HI : OFF_VAL2_HI);
            assign wr_ctrl[u] = reg_wr && reg_addr == (u == 0 ? OFF_CTRL1 : OFF_CTRL2);

            // event selection per capture mode
            always_comb begin
                case (mode)
                    MODE_CAP_FE: edge_ok = fall;
                    MODE_CAP_RE: edge_ok = rise;
                    MODE_CAP_4:  edge_ok = rise && presc_q[u] == PRESC_4;
                    MODE_CAP_16: edge_ok = rise && presc_q[u] == PRESC_16;
                    default:     edge_ok = 1'b0;
                endcase
            end
            assign cap_ev[u]     = (cls == CCPU_CAP) && edge_ok;
            assign cmp_ev[u]     = (cls == CCPU_CMP) && ({val_hi_q[u], val_lo_q[u]} == timer_a_count);
            assign trig_ev[u]    = cmp_ev[u] && mode == MODE_CMP_EV;
            assign period_end[u] = (cls == CCPU_PWM) && timer_b_inc
                                   && (timer_b_count == timer_b_period);

            // edge prescaler; a direct switch between capture codes keeps the count
            always_ff @(posedge clk_sys) begin
                if (reset || cls != CCPU_CAP) begin
                    presc_q[u] <= 4'h0;
                end else if (rise && (mode == MODE_CAP_4 || mode == MODE_CAP_16)) begin
                    presc_q[u] <= (mode == MODE_CAP_4 && presc_q[u] == PRESC_4) ? 4'h0
                                  : presc_q[u] + 4'h1;
                end
            end

            // value low byte; capture first, then software write
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    val_lo_q[u] <= 8'h00;
                end else if (cap_ev[u]) begin
                    val_lo_q[u] <= timer_a_count[7:0];
                end else if (wr_lo[u]) begin
                    val_lo_q[u] <= reg_wdata;
                end
            end

            // value high byte; duty buffer in pwm, read-only there
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    val_hi_q[u]   <= 8'h00;
                    duty_lsb_q[u] <= 2'h0;
                end else if (cap_ev[u]) begin
                    val_hi_q[u] <= timer_a_count[15:8];
                end else if (period_end[u]) begin
                    val_hi_q[u]   <= val_lo_q[u];
                    duty_lsb_q[u] <= ctrl_q[u][DUTY_LSB +: 2];
                end else if (wr_hi[u] && cls != CCPU_PWM) begin
                    val_hi_q[u] <= reg_wdata;
                end
            end

            // control register
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    ctrl_q[u] <= 6'h00;
                end else if (wr_ctrl[u]) begin
                    ctrl_q[u] <= reg_wdata[5:0] & CTRL_MASK;
                end
            end

            // output latch: compare actions and pwm waveform
            assign duty_buf = {val_hi_q[u], duty_lsb_q[u]};
            always_ff @(posedge clk_sys) begin
                if (reset || cls == CCPU_OFF) begin
                    out_q[u] <= 1'b0;
                end else if (cmp_ev[u] && mode == MODE_CMP_HI) begin
                    out_q[u] <= 1'b1;
                end else if (cmp_ev[u] && mode == MODE_CMP_LO) begin
                    out_q[u] <= 1'b0;
                end else if (period_end[u]) begin
                    out_q[u] <= ({val_lo_q[u], ctrl_q[u][DUTY_LSB +: 2]} != 10'h000);
                end else if (cls == CCPU_PWM && duty_buf == {timer_b_count, timer_b_subcount}) begin
                    out_q[u] <= 1'b0;
                end
            end
        end
    endgenerate

    // event flags: hardware set wins over software clear
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            flag_q <= 2'h0;
        end else begin
            flag_q[0] <= (cap_ev[0] | cmp_ev[0]) |
                         (flag_q[0] & ~first_unit_flag_clear);
            if (cap_ev[1] | cmp_ev[1]) begin
                flag_q[1] <= 1'b1;
            end else if (reg_wr && reg_addr == OFF_FLAG2) begin
                flag_q[1] <= reg_wdata[FLAG2_BIT];
            end
        end
    end

    // event enables
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ena_q <= 2'h0;
        end else begin
            if (reg_wr && reg_addr == OFF_ENA1) ena_q[0] <= reg_wdata[FLAG1_BIT];
            if (reg_wr && reg_addr == OFF_ENA2) ena_q[1] <= reg_wdata[FLAG2_BIT];
        end
    end

    // trigger and period-end strobes; no overflow flag is touched here
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            timer_a_clear <= 1'b0;
            adc_start     <= 1'b0;
            timer_b_clear <= 1'b0;
        end else begin
            timer_a_clear <= |trig_ev;
            adc_start     <= trig_ev[1] & adc_enabled;
            timer_b_clear <= |period_end;
        end
    end

    // read mux, data one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                OFF_VAL1_LO: rdata_q <= val_lo_q[0];
                OFF_VAL1_HI: rdata_q <= val_hi_q[0];
                OFF_CTRL1:   rdata_q <= {2'h0, ctrl_q[0]};
                OFF_VAL2_LO: rdata_q <= val_lo_q[1];
                OFF_VAL2_HI: rdata_q <= val_hi_q[1];
                OFF_CTRL2:   rdata_q <= {2'h0, ctrl_q[1]};
                OFF_FLAG2:   rdata_q <= {7'h00, flag_q[1]};
                OFF_ENA2:    rdata_q <= {7'h00, ena_q[1]};
                OFF_ENA1:    rdata_q <= {5'h00, ena_q[0], 2'h0};
                default:     rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata               = rdata_q;
    assign unit_pin_out            = out_q;
    assign first_unit_event_flag   = flag_q[0];
    assign first_unit_event_enable = ena_q[0];

    // checks
    property p_cap_load;
        @(posedge clk_sys) disable iff (reset)
        cap_ev[0] |=> {val_hi_q[0], val_lo_q[0]} == $past(timer_a_count);
    endproperty
    a_cap_load: assert property (p_cap_load) else $error("capture value wrong");

    property p_flag_set;
        @(posedge clk_sys) disable iff (reset)
        (cap_ev[1] | cmp_ev[1]) |=> flag_q[1];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_presc_clr;
        @(posedge clk_sys) disable iff (reset)
        g_unit[0].cls != CCPU_CAP |=> presc_q[0] == 4'h0;
    endproperty
    a_presc_clr: assert property (p_presc_clr) else $error("prescaler kept");

    property p_off_low;
        @(posedge clk_sys) disable iff (reset)
        g_unit[1].cls == CCPU_OFF |=> !out_q[1];
    endproperty
    a_off_low: assert property (p_off_low) else $error("latch not low");

    property p_sw_pin;
        @(posedge clk_sys) disable iff (reset)
        (cmp_ev[0] && g_unit[0].mode == MODE_CMP_SW && !wr_ctrl[0]) |=> $stable(out_q[0]);
    endproperty
    a_sw_pin: assert property (p_sw_pin) else $error("pin changed");

    property p_trig;
        @(posedge clk_sys) disable iff (reset)
        trig_ev[1] && adc_enabled |=> timer_a_clear && adc_start;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger missing");

    property p_cmp_hi;
        @(posedge clk_sys) disable iff (reset)
        cmp_ev[0] && g_unit[0].mode == MODE_CMP_HI |=> out_q[0];
    endproperty
    a_cmp_hi: assert property (p_cmp_hi) else $error("pin not high");

    property p_duty_latch;
        @(posedge clk_sys) disable iff (reset)
        period_end[0] |=> val_hi_q[0] == $past(val_lo_q[0]) && timer_b_clear;
    endproperty
    a_duty_latch: assert property (p_duty_latch) else $error("duty not latched");

    property p_tb_clear;
        @(posedge clk_sys) disable iff (reset)
        period_end[1] |=> timer_b_clear;
    endproperty
    a_tb_clear: assert property (p_tb_clear) else $error("timer b not cleared");

    property p_pwm_zero;
        @(posedge clk_sys) disable iff (reset)
        period_end[0] && {val_lo_q[0], ctrl_q[0][DUTY_LSB +: 2]} == 10'h000 |=> !out_q[0];
    endproperty
    a_pwm_zero: assert property (p_pwm_zero) else $error("zero duty set pin");

    property p_pwm_set;
        @(posedge clk_sys) disable iff (reset)
        period_end[0] && {val_lo_q[0], ctrl_q[0][DUTY_LSB +: 2]} != 10'h000 |=> out_q[0];
    endproperty
    a_pwm_set: assert property (p_pwm_set) else $error("pin not set at period end");

    property p_hi_ro;
        @(posedge clk_sys) disable iff (reset)
        wr_hi[0] && g_unit[0].cls == CCPU_PWM && !period_end[0] |=> $stable(val_hi_q[0]);
    endproperty
    a_hi_ro: assert property (p_hi_ro) else $error("high byte written in pwm");

    property p_trig_one;
        @(posedge clk_sys) disable iff (reset)
        trig_ev[0] && !trig_ev[1] |=> timer_a_clear && !adc_start;
    endproperty
    a_trig_one: assert property (p_trig_one) else $error("first unit trigger wrong");

    property p_flag_hold;
        @(posedge clk_sys) disable iff (reset)
        flag_q[0] && !first_unit_flag_clear |=> flag_q[0];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

    c_cap:  cover property (@(posedge clk_sys) cap_ev[0]);
    c_trig: cover property (@(posedge clk_sys) trig_ev[1]);
    c_cap16: cover property (@(posedge clk_sys) cap_ev[0] && g_unit[0].mode == MODE_CAP_16);
    c_pwm:  cover property (@(posedge clk_sys) period_end[0] ##[1:300] !out_q[0]);
endmodule

// ### ccpu_top_bench.sv
// self-checking bench of the two-unit capture/compare/pwm block
`timescale 1ns/1ns
module ccpu_top_bench;
    import ccpu_pkg::*;
    logic        clk_sys, reset, wr, rd, fclr, adc_en, run;
    logic [7:0]  addr, wdata, rdata, tb_per, d, d2;
    logic [7:0]  tb_cnt = 8'h00;
    logic [1:0]  sub = 2'h0;
    logic [15:0] ta, lf;
    logic [1:0]  ext, pout, pin, sv;
    logic        ta_clr, tb_clr, adc_st, f1, e1;
    int          miscompares, total_checks;
    int          n, m;
    logic [3:0]  cm [4] = '{MODE_CAP_FE, MODE_CAP_RE, MODE_CAP_4, MODE_CAP_16};
    int          cn [4] = '{1, 1, 4, 16};
    logic [3:0]  km [4] = '{MODE_CMP_HI, MODE_CMP_SW, MODE_CMP_LO, MODE_CMP_HI};
    logic        ke [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    logic [9:0]  pd [2] = '{10'h3ff, 10'h000};

    ccpu_top dut_u (
        .clk_sys(clk_sys), .reset(reset), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .timer_a_count(ta),
        .timer_b_count(tb_cnt), .timer_b_period(tb_per), .timer_b_subcount(sub),
        .timer_b_inc(run && sub == 2'h3), .adc_enabled(adc_en), .unit_pin_in(pin),
        .unit_pin_out(pout), .timer_a_clear(ta_clr), .timer_b_clear(tb_clr),
        .adc_start(adc_st), .first_unit_event_flag(f1), .first_unit_flag_clear(fclr),
        .first_unit_event_enable(e1)
    );
    ccpu_pin_model pm_u (.clk_sys(clk_sys), .ext_lvl(ext), .as_output(2'h0),
        .latch_out(pout), .pin(pin));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // timer b stand-in: four sub-phases per increment, wraps at the period
    always @(posedge clk_sys) begin
        if (run) begin
            sub <= sub + 2'h1;
            if (sub == 2'h3) tb_cnt <= (tb_cnt == tb_per) ? 8'h00 : tb_cnt + 8'h01;
        end
    end

    function automatic logic [15:0] nxt(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    // pin level once a duty has settled: 0% never sets, over-long never clears
    function automatic logic pwm_level(input logic [9:0] dt, input logic [7:0] p);
        return (dt != 10'h000) && (dt > {p, 2'h3});
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd_reg(a, v);
        check(16'(v), 16'(e));
    endtask

    task automatic clr_flag;
        @(posedge clk_sys);
        fclr <= 1'b1;
        @(posedge clk_sys);
        fclr <= 1'b0;
    endtask

    // one full pin pulse, slow enough for the synchroniser
    task automatic pulse;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_sys);
            ext[0] <= ~ext[0];
            cyc(6);
        end
    endtask

    // bounded window: collects trigger strobes as {conversion, timer clear}
    task automatic trig(input logic [7:0] c, input logic [15:0] v, output logic [1:0] s);
        s = 2'h0;
        ta <= ~v;
        wr_reg(c - 8'h02, v[7:0]);
        wr_reg(c - 8'h01, v[15:8]);
        wr_reg(c, {4'h0, MODE_CMP_EV});
        ta <= v;
        for (int i = 0; i < 12; i++) begin
            @(posedge clk_sys);
            #1 s = s | {adc_st, ta_clr};
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        {wr, rd, fclr, adc_en, run} = 5'h00;
        {addr, wdata, ta, ext} = 34'h0;
        tb_per = 8'h04;
        lf = 16'hf66a;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        // reset values, unused bits and an unmapped address
        rchk(OFF_CTRL1, 8'h00);
        rchk(OFF_CTRL2, 8'h00);
        rchk(OFF_FLAG2, 8'h00);
        wr_reg(8'h40, 8'hff);
        rchk(8'h40, 8'h00);
        wr_reg(OFF_ENA2, 8'h01);
        rchk(OFF_ENA2, 8'h01);
        wr_reg(OFF_CTRL2, 8'hf0);
        rchk(OFF_CTRL2, 8'h30);
        wr_reg(OFF_ENA1, 8'h04);
        cyc(1);
        check(16'(e1), 16'h1);
        // capture every edge mode; off first so the prescaler restarts
        for (int i = 0; i < 4; i++) begin
            wr_reg(OFF_CTRL1, 8'h00);
            ext[0] <= (i == 0);
            cyc(8);
            wr_reg(OFF_CTRL1, {4'h0, cm[i]});
            clr_flag;
            lf = nxt(lf);
            ta <= lf;
            repeat ((cn[i] > 1) ? cn[i] - 1 : 1) pulse;
            if (cn[i] > 1) check(16'(f1), 16'h0);
            lf = nxt(lf);
            ta <= lf;
            pulse;
            check(16'(f1), 16'h1);
            rd_reg(OFF_VAL1_LO, d);
            rd_reg(OFF_VAL1_HI, d2);
            check({d2, d}, lf);
        end
        // compare on unit one with the timer held on the match value
        wr_reg(OFF_CTRL1, 8'h00);
        lf = nxt(lf);
        wr_reg(OFF_VAL1_LO, lf[7:0]);
        wr_reg(OFF_VAL1_HI, lf[15:8]);
        for (int i = 0; i < 4; i++) begin
            ta <= ~lf; // no match while mode and flag are set up
            wr_reg(OFF_CTRL1, {4'h0, km[i]});
            clr_flag;
            cyc(1);
            check(16'(f1), 16'h0);
            ta <= lf;
            cyc(4);
            check(16'(pout[0]), 16'(ke[i]));
            check(16'(f1), 16'h1);
        end
        wr_reg(OFF_CTRL1, 8'h00);
        cyc(2);
        check(16'(pout[0]), 16'h0);
        // special event: only the second unit starts a conversion
        adc_en <= 1'b1;
        lf = nxt(lf);
        trig(OFF_CTRL2, lf, sv);
        check(16'(sv), 16'h3);
        rchk(OFF_FLAG2, 8'h01);
        wr_reg(OFF_CTRL2, 8'h00);
        trig(OFF_CTRL1, nxt(lf), sv);
        check(16'(sv), 16'h1);
        wr_reg(OFF_CTRL1, 8'h00);
        // pwm: over-long duty holds high, then 0% duty from the next period
        run <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            wr_reg(OFF_VAL1_LO, pd[i][9:2]);
            wr_reg(OFF_CTRL1, {2'h0, pd[i][1:0], 4'hc});
            wr_reg(OFF_VAL1_HI, 8'h5a);
            cyc(100);
            check(16'(pout[0]), 16'(pwm_level(pd[i], tb_per)));
            rchk(OFF_VAL1_HI, pd[i][9:2]);
        end
        // mid duty 9 over a 20 sub-count period; one register stage may add a cycle
        wr_reg(OFF_VAL1_LO, 8'h02);
        wr_reg(OFF_CTRL1, 8'h1c);
        cyc(60);
        n = 0;
        m = 0;
        repeat (20) begin
            cyc(1);
            n += int'(pout[0]);
            m += int'(tb_clr);
        end
        check(16'(n == 9 || n == 10), 16'h1);
        check(16'(m), 16'h1);
        // timer stopped so no period end can hide a refused write
        run <= 1'b0;
        wr_reg(OFF_VAL1_HI, 8'h5a);
        rchk(OFF_VAL1_HI, 8'h02);
        give_verdict;
    end
endmodule
